// ### hdl/cpf_pkg.sv
// Purpose: constants, types and window helpers for the cpu/pci bridge
// Assumes: apb slave on the cpu clock, pci logic on its own clock
// Notes: window registers are quasi-static once programmed
// What this block does
// - master buffer: four words, one transaction
// - write data taken at cpu rate, 4-word burst
// - latch address, store words, then request pci
// - further pci write stalls until buffer drains
// - full before grant raises write_accept_ok_n
// - non-pci writes complete after decode
// - multi-word read uses pci burst
// - cpu stalled until read word buffered
// - sub-word access moves only requested bytes
// - target path serviced while awaiting grant
// - eight-word target buffer, one transaction
// - two window registers, reset to zero
// - hit replaces the compared top bits with local base
// - bit 12 enables window
// - cleared mask bits drop address bits 27-21 from the compare
// - match field compared with address 31:21
package cpf_pkg;
  localparam logic [31:0] TW1_OFS = 32'h0000_001c;
  localparam logic [31:0] TW2_OFS = 32'h0000_0020;
  localparam logic [31:0] TW_RST = 32'h0000_0000;
  localparam logic [31:0] TW_WMASK = 32'hffef_f7ff;
  localparam int EN_BIT = 12;
  localparam int MSK_LSB = 13;
  localparam int MSK_W = 7;
  localparam int MATCH_LSB = 21;
  localparam int MBUF_WORDS = 4;
  localparam int TBUF_WORDS = 8;
  localparam logic [3:0] TBUF_FULL = 4'h8;
  localparam logic [3:0] BE_ALL = 4'hf;
  localparam int WIN_GAP_CLKS = 2;
  localparam int BASE_HI = 10;

  typedef enum logic [3:0] {
    C_IDLE = 4'h1,
    C_WFILL = 4'h2,
    C_WAIT = 4'h4,
    C_RRET = 4'h8
  } cpf_cst_t;

  typedef enum logic [2:0] {
    P_IDLE = 3'h1,
    P_REQ = 3'h2,
    P_XFER = 3'h4
  } cpf_pst_t;

  typedef struct packed {
    cpf_cst_t st;
    logic [MBUF_WORDS-1:0][31:0] data;
    logic [31:0] addr;
    logic [3:0] be;
    logic [2:0] n;
    logic [2:0] wcnt;
    logic [2:0] rcnt;
    logic wr;
    logic req_tgl;
    logic d1;
    logic d2;
    logic d3;
    logic ok_n;
    logic ack;
    logic [31:0] rdata;
    logic [31:0] win1;
    logic [31:0] win2;
    logic win_tgl;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } cpf_cs_t;

  typedef struct packed {
    cpf_pst_t st;
    logic r1;
    logic r2;
    logic r3;
    logic w1;
    logic w2;
    logic w3;
    logic done_tgl;
    logic [2:0] idx;
    logic [2:0] cnt;
    logic [MBUF_WORDS-1:0][31:0] rdbuf;
    logic [31:0] pw1;
    logic [31:0] pw2;
    logic req;
    logic valid;
    logic burst;
    logic wr;
    logic [31:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
    logic tbusy;
    logic tend;
    logic thit;
    logic [31:0] maddr;
    logic [3:0] mbe;
    logic [TBUF_WORDS-1:0][31:0] tbuf;
    logic [3:0] wp;
    logic [3:0] rp;
    logic mvalid;
    logic [31:0] mdata;
    logic wready;
  } cpf_ps_t;

  // compare mask over address bits 31:21; top four bits always compared
  function automatic logic [31:0] win_mask(input logic [31:0] w);
    return {4'hf, w[MSK_LSB +: MSK_W], 21'h0};
  endfunction

  function automatic logic win_hit(input logic [31:0] w, input logic [31:0] a);
    return w[EN_BIT] && (((w ^ a) & win_mask(w)) == 32'h0);
  endfunction

  function automatic logic [31:0] win_xlate(input logic [31:0] w, input logic [31:0] a);
    return ({w[BASE_HI:0], 21'h0} & win_mask(w)) | (a & ~win_mask(w));
  endfunction
endpackage

// ### hdl/cpf_bridge.sv
// Purpose: cpu-to-pci master buffer and pci target window decode
// Assumes: cpu beats are valid/ack handshakes; pci side is simple valid/trdy logic
// Notes: target path is write-only toward memory; reads leave through pci rdbuf
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
module cpf_bridge
  import cpf_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic cpu_valid_i,
  input wire logic cpu_wr_i,
  input wire logic cpu_pci_i,
  input wire logic [2:0] cpu_nwords_i,
  input wire logic [31:0] cpu_addr_i,
  input wire logic [3:0] cpu_be_i,
  input wire logic [31:0] cpu_wdata_i,
  output logic cpu_ack_o,
  output logic [31:0] cpu_rdata_o,
  output logic write_accept_ok_n_o,
  input wire logic pci_clk_i,
  output logic pci_req_o,
  input wire logic pci_gnt_i,
  output logic pci_valid_o,
  output logic pci_burst_o,
  output logic pci_wr_o,
  output logic [31:0] pci_addr_o,
  output logic [3:0] pci_be_o,
  output logic [31:0] pci_wdata_o,
  input wire logic pci_trdy_i,
  input wire logic [31:0] pci_rdata_i,
  input wire logic tgt_start_i,
  input wire logic [31:0] tgt_addr_i,
  input wire logic [3:0] tgt_be_i,
  input wire logic tgt_wvalid_i,
  input wire logic [31:0] tgt_wdata_i,
  input wire logic tgt_end_i,
  output logic tgt_hit_o,
  output logic tgt_wready_o,
  output logic [31:0] mem_addr_o,
  output logic [3:0] mem_be_o,
  output logic mem_valid_o,
  output logic [31:0] mem_data_o,
  input wire logic mem_pop_i
);
  cpf_cs_t c;
  cpf_cs_t c_nxt;
  cpf_ps_t p;
  cpf_ps_t p_nxt;
  logic [2:0] prst_s_r;
  logic prst_r;
  logic done_ev;
  logic acc;
  logic req_ev;
  logic win_ev;
  logic h1;
  logic h2;
  logic [31:0] x1;

  assign done_ev = c.d2 ^ c.d3;
  assign acc = cpu_valid_i && !c.ack;
  assign req_ev = p.r2 ^ p.r3;
  assign win_ev = p.w2 ^ p.w3;
  assign h1 = win_hit(p.pw1, tgt_addr_i);
  assign h2 = win_hit(p.pw2, tgt_addr_i);
  assign x1 = win_xlate(p.pw1, tgt_addr_i);

  always_comb
  begin
    c_nxt = c;
    c_nxt.ack = 1'b0;
    c_nxt.pready = 1'b0;
    c_nxt.pslverr = 1'b0;
    c_nxt.d1 = p.done_tgl;
    c_nxt.d2 = c.d1;
    c_nxt.d3 = c.d2;
    // one wait state, so pready comes from a flop
    if (psel_i && penable_i && !c.pready)
    begin
      c_nxt.pready = 1'b1;
      if (paddr_i == TW1_OFS)
        c_nxt.prdata = c.win1;
      else if (paddr_i == TW2_OFS)
        c_nxt.prdata = c.win2;
      else
      begin
        c_nxt.prdata = 32'h0;
        c_nxt.pslverr = 1'b1;
      end
    end
    if (psel_i && penable_i && c.pready && pwrite_i)
    begin
      if (paddr_i == TW1_OFS)
      begin
        c_nxt.win1 = pwdata_i & TW_WMASK;
        c_nxt.win_tgl = ~c.win_tgl;
      end
      else if (paddr_i == TW2_OFS)
      begin
        c_nxt.win2 = pwdata_i & TW_WMASK;
        c_nxt.win_tgl = ~c.win_tgl;
      end
    end
    // non-pci cycles finish once decoded, unless the cpu is held
    if (acc && !cpu_pci_i && !c.ok_n &&
        (c.st == C_IDLE || (c.st == C_WAIT && c.wr)))
      c_nxt.ack = 1'b1;
    case (c.st)
      C_IDLE:
      begin
        if (acc && cpu_pci_i)
        begin
          c_nxt.addr = cpu_addr_i;
          c_nxt.be = cpu_be_i;
          c_nxt.wr = cpu_wr_i;
          c_nxt.n = cpu_nwords_i;
          c_nxt.data[0] = cpu_wdata_i;
          c_nxt.wcnt = 3'h1;
          if (cpu_wr_i)
          begin
            c_nxt.ack = 1'b1;
            if (cpu_nwords_i > 3'h1)
              c_nxt.st = C_WFILL;
            else
            begin
              c_nxt.req_tgl = ~c.req_tgl;
              c_nxt.st = C_WAIT;
            end
          end
          else
          begin
            c_nxt.req_tgl = ~c.req_tgl;
            c_nxt.st = C_WAIT;
          end
        end
      end
      C_WFILL:
      begin
        if (acc)
        begin
          c_nxt.data[c.wcnt[1:0]] = cpu_wdata_i;
          c_nxt.wcnt = 3'(c.wcnt + 3'h1);
          c_nxt.ack = 1'b1;
          if (3'(c.wcnt + 3'h1) == c.n)
          begin
            c_nxt.req_tgl = ~c.req_tgl;
            // buffer is full and the bus cannot be owned yet
            c_nxt.ok_n = 1'b1;
            c_nxt.st = C_WAIT;
          end
        end
      end
      C_WAIT:
      begin
        // acked pci writes and unanswered pci reads wait here for the pci side to finish
        if (done_ev)
        begin
          c_nxt.ok_n = 1'b0;
          if (c.wr)
            c_nxt.st = C_IDLE;
          else
          begin
            c_nxt.data = p.rdbuf;
            c_nxt.rcnt = 3'h0;
            c_nxt.st = C_RRET;
          end
        end
      end
      C_RRET:
      begin
        if (acc)
        begin
          c_nxt.rdata = c.data[c.rcnt[1:0]];
          c_nxt.ack = 1'b1;
          c_nxt.rcnt = 3'(c.rcnt + 3'h1);
          if (3'(c.rcnt + 3'h1) == c.n)
            c_nxt.st = C_IDLE;
        end
      end
      default:
        c_nxt.st = C_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      c <= '0;
      c.st <= C_IDLE;
    end
    else
      c <= c_nxt;
  end

  // reset brought into the pci domain; taken only once two stages agree
  always_ff @(posedge pci_clk_i)
  begin
    prst_s_r <= {prst_s_r[1:0], rst_i};
    if (prst_s_r[2] == prst_s_r[1])
      prst_r <= prst_s_r[2];
  end

  always_comb
  begin
    p_nxt = p;
    p_nxt.r1 = c.req_tgl;
    p_nxt.r2 = p.r1;
    p_nxt.r3 = p.r2;
    p_nxt.w1 = c.win_tgl;
    p_nxt.w2 = p.w1;
    p_nxt.w3 = p.w2;
    // window words are stable once the toggle lands
    if (win_ev)
    begin
      p_nxt.pw1 = c.win1;
      p_nxt.pw2 = c.win2;
    end
    case (p.st)
      P_IDLE:
      begin
        if (req_ev)
        begin
          p_nxt.addr = c.addr;
          p_nxt.wr = c.wr;
          p_nxt.cnt = c.n;
          p_nxt.be = (c.n == 3'h1) ? c.be : BE_ALL;
          p_nxt.burst = c.n > 3'h1;
          p_nxt.idx = 3'h0;
          p_nxt.req = 1'b1;
          p_nxt.st = P_REQ;
        end
      end
      P_REQ:
      begin
        if (pci_gnt_i)
        begin
          p_nxt.valid = 1'b1;
          p_nxt.wdata = c.data[0];
          p_nxt.st = P_XFER;
        end
      end
      P_XFER:
      begin
        if (pci_trdy_i)
        begin
          if (!p.wr)
            p_nxt.rdbuf[p.idx[1:0]] = pci_rdata_i;
          if (3'(p.idx + 3'h1) == p.cnt)
          begin
            p_nxt.valid = 1'b0;
            p_nxt.req = 1'b0;
            p_nxt.done_tgl = ~p.done_tgl;
            p_nxt.st = P_IDLE;
          end
          else
          begin
            p_nxt.idx = 3'(p.idx + 3'h1);
            p_nxt.wdata = c.data[2'(p.idx + 3'h1)];
          end
        end
      end
      default:
        p_nxt.st = P_IDLE;
    endcase
    // target path runs regardless of the master state
    if (tgt_start_i && !p.tbusy)
    begin
      p_nxt.thit = h1 || h2;
      if (h1 || h2)
      begin
        p_nxt.tbusy = 1'b1;
        p_nxt.maddr = h1 ? x1 : win_xlate(p.pw2, tgt_addr_i);
        p_nxt.mbe = tgt_be_i;
        p_nxt.wp = 4'h0;
        p_nxt.rp = 4'h0;
        p_nxt.tend = 1'b0;
      end
    end
    if (p.tbusy && tgt_wvalid_i && p.wready)
    begin
      p_nxt.tbuf[p.wp[2:0]] = tgt_wdata_i;
      p_nxt.wp = 4'(p.wp + 4'h1);
    end
    if (mem_pop_i && p.mvalid)
      p_nxt.rp = 4'(p.rp + 4'h1);
    if (p.tbusy && tgt_end_i)
      p_nxt.tend = 1'b1;
    if (p.tend && p.rp == p.wp && !p.mvalid)
    begin
      p_nxt.tbusy = 1'b0;
      p_nxt.tend = 1'b0;
      p_nxt.thit = 1'b0;
    end
    p_nxt.wready = p_nxt.tbusy && !p_nxt.tend && p_nxt.wp != TBUF_FULL;
    p_nxt.mvalid = p_nxt.tbusy && p_nxt.rp != p_nxt.wp;
    p_nxt.mdata = p_nxt.tbuf[p_nxt.rp[2:0]];
  end

  always_ff @(posedge pci_clk_i)
  begin
    if (prst_r)
    begin
      p <= '0;
      p.st <= P_IDLE;
    end
    else
      p <= p_nxt;
  end

  assign prdata_o = c.prdata;
  assign pready_o = c.pready;
  assign pslverr_o = c.pslverr;
  assign cpu_ack_o = c.ack;
  assign cpu_rdata_o = c.rdata;
  assign write_accept_ok_n_o = c.ok_n;
  assign pci_req_o = p.req;
  assign pci_valid_o = p.valid;
  assign pci_burst_o = p.burst;
  assign pci_wr_o = p.wr;
  assign pci_addr_o = p.addr;
  assign pci_be_o = p.be;
  assign pci_wdata_o = p.wdata;
  assign tgt_hit_o = p.thit;
  assign tgt_wready_o = p.wready;
  assign mem_addr_o = p.maddr;
  assign mem_be_o = p.mbe;
  assign mem_valid_o = p.mvalid;
  assign mem_data_o = p.mdata;

  full_flag_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (c.st == C_WFILL ##1 c.st == C_WAIT) |-> write_accept_ok_n_o)
    else $error("ok_n not raised on full buffer");
  fill_first_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ($changed(c.req_tgl) && c.wr) |-> c.wcnt == c.n)
    else $error("pci request before buffer filled");
  wr_stall_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (c.st == C_WAIT && cpu_valid_i && cpu_pci_i) |=> !cpu_ack_o)
    else $error("pci access acked while buffer busy");
  local_ack_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (c.st == C_IDLE && cpu_valid_i && !cpu_pci_i && !c.ack) |=> cpu_ack_o)
    else $error("non-pci write not completed");
  rd_hold_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (c.st == C_WAIT && !c.wr) |=> !cpu_ack_o)
    else $error("cpu released before read data");
  win_reset_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    $fell(rst_i) |-> (c.win1 == TW_RST && c.win2 == TW_RST))
    else $error("window not cleared by reset");
  win_rsv_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (c.win1[11] | c.win1[20] | c.win2[11] | c.win2[20]) == 1'b0)
    else $error("reserved window bit set");
  rd_burst_a: assert property (@(posedge pci_clk_i) disable iff (prst_r)
    (p.st == P_IDLE && req_ev && c.n > 3'h1) |=> pci_burst_o && pci_be_o == BE_ALL)
    else $error("multi-word access not a burst");
  sub_word_a: assert property (@(posedge pci_clk_i) disable iff (prst_r)
    (p.st == P_IDLE && req_ev && c.n == 3'h1) |=> pci_be_o == $past(c.be))
    else $error("byte enables not passed through");
  win_miss_a: assert property (@(posedge pci_clk_i) disable iff (prst_r)
    (tgt_start_i && !p.tbusy && !h1 && !h2) |=> !tgt_hit_o && !p.tbusy)
    else $error("target claimed without window match");
  xlate_a: assert property (@(posedge pci_clk_i) disable iff (prst_r)
    (tgt_start_i && !p.tbusy && h1) |=> mem_addr_o == $past(x1))
    else $error("memory address not translated");
  tbuf_full_a: assert property (@(posedge pci_clk_i) disable iff (prst_r)
    (p.wp == TBUF_FULL) |-> !tgt_wready_o)
    else $error("target buffer overrun");

  wr_burst_c: cover property (@(posedge ref_clk_i) disable iff (rst_i)
    c.st == C_WFILL ##1 c.st == C_WAIT);
  rd_ret_c: cover property (@(posedge ref_clk_i) disable iff (rst_i)
    c.st == C_RRET ##1 c.st == C_IDLE);
  tgt_wait_c: cover property (@(posedge pci_clk_i) disable iff (prst_r)
    p.st == P_REQ && tgt_start_i && (h1 || h2));
endmodule // cpf_bridge

// ### sim/cpf_pci_far.sv
// Purpose: far-side pci target answering the bridge while it is bus master
// Assumes: one transaction at a time; grant delay is at least one pci clock
// Notes: a long grant delay opens a window for target traffic during a master write
`timescale 1ns/1ps
module cpf_pci_far
(
  input wire logic pci_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] gnt_dly_i,
  input wire logic pci_req_i,
  input wire logic pci_valid_i,
  input wire logic pci_wr_i,
  input wire logic pci_burst_i,
  input wire logic [3:0] pci_be_i,
  input wire logic [31:0] pci_wdata_i,
  output logic pci_gnt_o,
  output logic pci_trdy_o,
  output logic [31:0] pci_rdata_o,
  output logic [2:0] wcnt_o,
  output logic [31:0] wlast_o,
  output logic [3:0] be_o,
  output logic burst_o
);
  logic [7:0] wait_r;
  logic [2:0] idx_r;
  assign pci_trdy_o = pci_valid_i & pci_gnt_o;
  // read words count up per transaction; released data is inverted so it never looks valid
  assign pci_rdata_o = pci_valid_i ? {16'hc0de, 13'h0, idx_r} : ~{16'hc0de, 13'h0, idx_r};
  always_ff @(posedge pci_clk_i)
  begin
    if (rst_i || !pci_req_i)
    begin
      wait_r <= 8'h00;
      pci_gnt_o <= 1'b0;
      idx_r <= 3'h0;
    end
    else
    begin
      wait_r <= wait_r + ((wait_r < gnt_dly_i) ? 8'h01 : 8'h00);
      pci_gnt_o <= (wait_r >= gnt_dly_i);
      if (pci_trdy_o)
        idx_r <= idx_r + 3'h1;
    end
  end
  always_ff @(posedge pci_clk_i)
  begin
    if (rst_i)
    begin
      wcnt_o <= 3'h0;
      wlast_o <= 32'h0;
      be_o <= 4'h0;
      burst_o <= 1'b0;
    end
    else
    begin
      if (pci_req_i && wait_r == 8'h00)
        wcnt_o <= 3'h0;
      else if (pci_trdy_o && pci_wr_i)
      begin
        wcnt_o <= wcnt_o + 3'h1;
        wlast_o <= pci_wdata_i;
        be_o <= pci_be_i;
      end
      if (pci_trdy_o)
        burst_o <= pci_burst_i;
    end
  end
endmodule // cpf_pci_far

// ### sim/cpu_pci_fifo_and_target_windows_bench.sv
// Purpose: self-checking bench for the cpu/pci bridge and target windows
// Assumes: apb and cpu beats on the ref clock, target traffic on the pci clock
// Notes: reset is held 5 cycles, which the pci side samples on two edges
`timescale 1ns/1ps
module cpu_pci_fifo_and_target_windows_bench
  import cpf_pkg::*;
;
  logic ref_clk_i, pci_clk_i, rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic [31:0] paddr_i, pwdata_i, prdata_o, cpu_addr_i, cpu_wdata_i, cpu_rdata_o, pci_addr_o;
  logic cpu_valid_i, cpu_wr_i, cpu_pci_i, cpu_ack_o, write_accept_ok_n_o, pci_req_o, pci_gnt_i;
  logic [2:0] cpu_nwords_i, wcnt;
  logic [3:0] cpu_be_i, pci_be_o, tgt_be_i, mem_be_o, be_seen;
  logic pci_valid_o, pci_burst_o, pci_wr_o, pci_trdy_i, tgt_start_i, tgt_wvalid_i, tgt_end_i;
  logic [31:0] pci_wdata_o, pci_rdata_i, tgt_addr_i, tgt_wdata_i, mem_addr_o, mem_data_o, wlast;
  logic tgt_hit_o, tgt_wready_o, mem_valid_o, mem_pop_i, burst_seen;
  logic [7:0] gnt_dly;
  logic [31:0] seed, w1, w2, a, q, d;
  int bad_count, tests_run, i, k, cyc;

  cpf_bridge dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .cpu_valid_i(cpu_valid_i), .cpu_wr_i(cpu_wr_i),
    .cpu_pci_i(cpu_pci_i), .cpu_nwords_i(cpu_nwords_i), .cpu_addr_i(cpu_addr_i),
    .cpu_be_i(cpu_be_i), .cpu_wdata_i(cpu_wdata_i), .cpu_ack_o(cpu_ack_o),
    .cpu_rdata_o(cpu_rdata_o), .write_accept_ok_n_o(write_accept_ok_n_o), .pci_clk_i(pci_clk_i),
    .pci_req_o(pci_req_o), .pci_gnt_i(pci_gnt_i), .pci_valid_o(pci_valid_o),
    .pci_burst_o(pci_burst_o), .pci_wr_o(pci_wr_o), .pci_addr_o(pci_addr_o), .pci_be_o(pci_be_o),
    .pci_wdata_o(pci_wdata_o), .pci_trdy_i(pci_trdy_i), .pci_rdata_i(pci_rdata_i),
    .tgt_start_i(tgt_start_i), .tgt_addr_i(tgt_addr_i), .tgt_be_i(tgt_be_i),
    .tgt_wvalid_i(tgt_wvalid_i), .tgt_wdata_i(tgt_wdata_i), .tgt_end_i(tgt_end_i),
    .tgt_hit_o(tgt_hit_o), .tgt_wready_o(tgt_wready_o), .mem_addr_o(mem_addr_o),
    .mem_be_o(mem_be_o), .mem_valid_o(mem_valid_o), .mem_data_o(mem_data_o), .mem_pop_i(mem_pop_i));
  cpf_pci_far far (.pci_clk_i(pci_clk_i), .rst_i(rst_i), .gnt_dly_i(gnt_dly),
    .pci_req_i(pci_req_o), .pci_valid_i(pci_valid_o), .pci_wr_i(pci_wr_o),
    .pci_burst_i(pci_burst_o), .pci_be_i(pci_be_o), .pci_wdata_i(pci_wdata_o),
    .pci_gnt_o(pci_gnt_i), .pci_trdy_o(pci_trdy_i), .pci_rdata_o(pci_rdata_i), .wcnt_o(wcnt),
    .wlast_o(wlast), .be_o(be_seen), .burst_o(burst_seen));

  function automatic logic hit(input logic [31:0] w, input logic [31:0] ad);
    return w[12] && (((w ^ ad) & {4'hf, w[19:13], 21'h0}) == 32'h0);
  endfunction
  function automatic logic [31:0] xl(input logic [31:0] w, input logic [31:0] ad);
    return ({w[10:0], 21'h0} & {4'hf, w[19:13], 21'h0}) | (ad & ~{4'hf, w[19:13], 21'h0});
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [31:0] ad, input logic [31:0] wd,
                     input logic [31:0] ex);
    int n;
    @(posedge ref_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= ad;
    pwdata_i <= wd;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    for (n = 0; n < 20 && pready_o !== 1'b1; n++)
      @(posedge ref_clk_i);
    chk({31'h0, pready_o}, 32'h1);
    if (!wr)
      chk(prdata_o, ex);
    chk({31'h0, pslverr_o}, {31'h0, ad != TW1_OFS && ad != TW2_OFS});
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic cpu(input logic wr, input logic pc, input logic [2:0] n, input logic [31:0] ad,
                     input logic [3:0] be, input logic [31:0] wd);
    @(posedge ref_clk_i);
    cpu_valid_i <= 1'b1;
    cpu_wr_i <= wr;
    cpu_pci_i <= pc;
    cpu_nwords_i <= n;
    cpu_addr_i <= ad;
    cpu_be_i <= be;
    cpu_wdata_i <= wd;
    for (cyc = 0; cyc < 400 && cpu_ack_o !== 1'b1; cyc++)
      @(posedge ref_clk_i);
    chk({31'h0, cpu_ack_o}, 32'h1);
    q = cpu_rdata_o;
    cpu_valid_i <= 1'b0;
  endtask

  task automatic tgt(input logic [31:0] w, input logic [31:0] ad, input int nw);
    int j, m;
    logic [31:0] d0;
    d0 = $random(seed);
    @(posedge pci_clk_i);
    tgt_start_i <= 1'b1;
    tgt_addr_i <= ad;
    tgt_be_i <= d0[3:0];
    @(posedge pci_clk_i);
    tgt_start_i <= 1'b0;
    repeat (2) @(posedge pci_clk_i);
    chk({31'h0, tgt_hit_o}, {31'h0, hit(w, ad)});
    if (tgt_hit_o === 1'b1)
    begin
      chk(mem_addr_o, xl(w, ad));
      chk({28'h0, mem_be_o}, {28'h0, d0[3:0]});
      for (j = 0; j < nw; j++)
      begin
        tgt_wvalid_i <= 1'b1;
        tgt_wdata_i <= d0 + j;
        @(posedge pci_clk_i);
        for (m = 0; m < 50 && tgt_wready_o !== 1'b1; m++)
          @(posedge pci_clk_i);
        chk({31'h0, tgt_wready_o}, 32'h1);
      end
      tgt_wvalid_i <= 1'b0;
      repeat (2) @(posedge pci_clk_i);
      chk({31'h0, tgt_wready_o}, {31'h0, nw < 8});
      mem_pop_i <= 1'b1;
      for (j = 0; j < nw; j++)
      begin
        @(posedge pci_clk_i);
        for (m = 0; m < 50 && mem_valid_o !== 1'b1; m++)
          @(posedge pci_clk_i);
        chk({31'h0, mem_valid_o}, 32'h1);
        chk(mem_data_o, d0 + j);
      end
      mem_pop_i <= 1'b0;
    end
    tgt_end_i <= 1'b1;
    @(posedge pci_clk_i);
    tgt_end_i <= 1'b0;
    repeat (3) @(posedge pci_clk_i);
    chk({31'h0, tgt_hit_o}, 32'h0);
  endtask

  initial
  begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end
  initial
  begin
    pci_clk_i = 1'b0;
    #7.3;
    forever #32 pci_clk_i = ~pci_clk_i;
  end
  initial
  begin
    #1_000_000;
    bad_count++;
    report_and_stop();
  end

  initial
  begin
    seed = 32'hcf4a3d52;
    {psel_i, penable_i, pwrite_i, cpu_valid_i, cpu_wr_i, cpu_pci_i} = 6'h00;
    {tgt_start_i, tgt_wvalid_i, tgt_end_i, mem_pop_i, cpu_nwords_i, cpu_be_i, tgt_be_i} = '0;
    {paddr_i, pwdata_i, cpu_addr_i, cpu_wdata_i, tgt_addr_i, tgt_wdata_i} = '0;
    gnt_dly = 8'h02;
    rst_i = 1'b1;
    repeat (5) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    apb(1'b0, TW1_OFS, 32'h0, 32'h0);
    apb(1'b0, TW2_OFS, 32'h0, 32'h0);
    apb(1'b0, 32'h0000_0024, 32'h0, 32'h0);
    w1 = $random(seed) | 32'h0010_1800;
    w2 = ($random(seed) | 32'h0010_0800) & 32'hffff_efff;
    w2[31:28] = ~w1[31:28];
    apb(1'b1, TW1_OFS, w1, 32'h0);
    apb(1'b1, TW2_OFS, w2, 32'h0);
    apb(1'b0, TW1_OFS, 32'h0, w1 & 32'hffef_f7ff);
    apb(1'b0, TW2_OFS, 32'h0, w2 & 32'hffef_f7ff);
    // window copies cross into the pci domain, so wait well beyond the minimum gap
    repeat (WIN_GAP_CLKS + 10) @(posedge ref_clk_i);
    a = {w1[31:21], 21'h0} | ($random(seed) & 32'h001f_fffc);
    tgt(w1, a, 8);
    tgt(w2, {w2[31:21], 21'h40}, 1);
    for (i = 0; i < 7; i++)
      tgt(w1, a ^ (32'h0020_0000 << i), 1);
    gnt_dly <= 8'h3c;
    d = $random(seed);
    for (i = 0; i < 4; i++)
      cpu(1'b1, 1'b1, 3'h4, a, 4'hf, d + i);
    repeat (3) @(posedge ref_clk_i);
    chk({31'h0, write_accept_ok_n_o}, 32'h1);
    tgt(w1, a, 2);
    cpu(1'b1, 1'b1, 3'h1, a, 4'h3, d);
    chk({29'h0, wcnt}, 32'h4);
    chk(wlast, d + 3);
    gnt_dly <= 8'h02;
    for (k = 0; k < 400 && wcnt !== 3'h1; k++)
      @(posedge ref_clk_i);
    chk({29'h0, wcnt}, 32'h1);
    chk(pci_addr_o, a);
    chk({28'h0, be_seen}, 32'h3);
    chk({31'h0, write_accept_ok_n_o}, 32'h0);
    cpu(1'b1, 1'b0, 3'h1, a, 4'hf, d);
    chk({31'h0, cyc < 3}, 32'h1);
    for (i = 0; i < 4; i++)
    begin
      cpu(1'b0, 1'b1, 3'h4, a, 4'hf, 32'h0);
      chk(q, 32'hc0de_0000 | i);
    end
    chk({31'h0, burst_seen}, 32'h1);
    cpu(1'b0, 1'b1, 3'h1, a, 4'h1, 32'h0);
    chk(q, 32'hc0de_0000);
    chk({28'h0, pci_be_o}, 32'h1);
    chk({31'h0, burst_seen}, 32'h0);
    cpu(1'b1, 1'b0, 3'h1, a, 4'hf, d);
    chk({31'h0, cyc < 3}, 32'h1);
    report_and_stop();
  end
endmodule // cpu_pci_fifo_and_target_windows_bench
